/* core/channel_diagnostic_reg_pkg.sv */
// constants, field layouts and carrier types for the switch fault diagnostics block
// assumes a single 200 MHz clock and a simple one-cycle register port
package channel_diagnostic_reg_pkg;
	localparam int NUM_CH = 4;
	localparam int CLK_MHZ = 200;
	// register indices on the plain register port
	localparam logic [3:0] ADDR_TOP_CHANNEL_DIAGNOSTIC_REG = 4'h0;
	localparam logic [3:0] ADDR_CHANNEL_DIAGNOSTIC_REG_B21 = 4'h1;
	localparam logic [3:0] ADDR_CHANNEL_DIAGNOSTIC_REG_B43 = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_CLEAR = 4'h4;
	localparam logic [3:0] ADDR_FAULT_MASK = 4'h5;
	localparam logic [3:0] ADDR_DEV_ADDR = 4'h6;
	// field positions
	localparam int LINK_ERR_BIT = 7;
	localparam int OC_HI_BIT = 7;
	localparam int OC_LO_BIT = 3;
	localparam int OL_HI_BIT = 4;
	localparam int OL_LO_BIT = 0;
	localparam int STATE_LSB = 4;
	// clear register layout: [3:0] over-current, [7:4] open-load; link error cleared from the top register
	localparam int CLR_OL_LSB = 4;
	localparam int CLR_LINK_BIT = 8;
	// fault mask layout: [0] over-current, [1] open-load, [2] link error
	localparam logic [7:0] FAULT_MASK_RST = 8'h05;
	localparam logic [7:0] RESET_ZERO = 8'h00;
	// link watchdog: silence longer than this is a loss of communication
	localparam int LINK_TIMEOUT_NS = 1000;
	localparam int LINK_TIMEOUT_CYC = (LINK_TIMEOUT_NS * CLK_MHZ) / 1000;
	localparam logic [7:0] LINK_CNT_ONE = 8'h01;
	localparam int DEV_ADDR_W = 5; // daisy chain of up to thirty-two

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	typedef struct packed {
		logic alive;      // heartbeat toggle from the switch side
		logic frame_err;  // framing or check error seen on the link
		logic sw_powered; // switch side supply good
	} link_in_s;
endpackage : channel_diagnostic_reg_pkg

/* core/switch_fault_diagnostics.sv */
// fault flags, link watchdog, output gating and indicator pins of a four-channel switch
// assumes a synchronous one-clock system; analogue comparators arrive as pin levels
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module switch_fault_diagnostics (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [channel_diagnostic_reg_pkg::NUM_CH-1:0] parallel_channel_input,
	input wire logic [channel_diagnostic_reg_pkg::NUM_CH-1:0] overcurrent_sense,
	input wire logic [channel_diagnostic_reg_pkg::NUM_CH-1:0] open_load_sense,
	input wire channel_diagnostic_reg_pkg::link_in_s link_in,
	input wire channel_diagnostic_reg_pkg::reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	output logic [channel_diagnostic_reg_pkg::NUM_CH-1:0] switch_drive,
	output logic [channel_diagnostic_reg_pkg::NUM_CH-1:0] channel_status_led_n_o,
	output logic [channel_diagnostic_reg_pkg::NUM_CH-1:0] channel_status_led_n_oe,
	output logic open_load_indicator_n_o,
	output logic open_load_indicator_n_oe,
	output logic fault_indicator_n_o,
	output logic fault_indicator_n_oe
);
	import channel_diagnostic_reg_pkg::*;

	// ==========================================================
	// input synchronisers
	// three stages per pin; a change counts when stages two and three agree
	logic [NUM_CH-1:0] pin_s1_q, pin_s2_q, pin_s3_q, cmd_q;
	logic [NUM_CH-1:0] oc_s1_q, oc_s2_q, oc_s3_q, oc_q;
	logic [NUM_CH-1:0] ol_s1_q, ol_s2_q, ol_s3_q, ol_q;
	logic [2:0] lk_s1_q, lk_s2_q, lk_s3_q, lk_q;

	// synchroniser stages, all pins in one place
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
			oc_s1_q <= '0;
			oc_s2_q <= '0;
			oc_s3_q <= '0;
			ol_s1_q <= '0;
			ol_s2_q <= '0;
			ol_s3_q <= '0;
			// link stages rest at the idle level: supply good, no error, heartbeat low,
			// so releasing reset does not look like a dead switch side
			lk_s1_q <= 3'h1;
			lk_s2_q <= 3'h1;
			lk_s3_q <= 3'h1;
		end else begin
			pin_s1_q <= parallel_channel_input; // dedicated one-way path
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			oc_s1_q <= overcurrent_sense;
			oc_s2_q <= oc_s1_q;
			oc_s3_q <= oc_s2_q;
			ol_s1_q <= open_load_sense;
			ol_s2_q <= ol_s1_q;
			ol_s3_q <= ol_s2_q;
			lk_s1_q <= link_in;
			lk_s2_q <= lk_s1_q;
			lk_s3_q <= lk_s2_q;
		end
	end

	// agreement filter: take a bit only when stages two and three match
	function automatic logic [NUM_CH-1:0] agree4(input logic [NUM_CH-1:0] a,
			input logic [NUM_CH-1:0] b, input logic [NUM_CH-1:0] old);
		agree4 = (a & b) | (old & (a ^ b));
	endfunction : agree4

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cmd_q <= '0;
			oc_q <= '0;
			ol_q <= '0;
			lk_q <= 3'h1; // idle link level, see the synchroniser reset
		end else begin
			cmd_q <= agree4(pin_s2_q, pin_s3_q, cmd_q); // bit 0 is channel zero
			oc_q <= agree4(oc_s2_q, oc_s3_q, oc_q);
			ol_q <= agree4(ol_s2_q, ol_s3_q, ol_q);
			lk_q <= (lk_s2_q & lk_s3_q) | (lk_q & (lk_s2_q ^ lk_s3_q));
		end
	end

	// ==========================================================
	// register port
	logic [NUM_CH-1:0] oc_flag_q, ol_flag_q;
	logic link_err_q;
	logic [7:0] fault_mask_q;
	logic [DEV_ADDR_W-1:0] dev_addr_q;
	logic [7:0] clr_q;
	logic clr_link_q;
	logic [NUM_CH-1:0] state_q;

	// configuration writes; clear strobes last one cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fault_mask_q <= FAULT_MASK_RST; // default sources
			dev_addr_q <= '0;
			clr_q <= RESET_ZERO;
			clr_link_q <= 1'b0;
		end else begin
			clr_q <= RESET_ZERO;
			clr_link_q <= 1'b0;
			if (reg_req.wr) begin
				case (reg_req.addr)
					ADDR_FAULT_MASK: fault_mask_q <= reg_req.wdata;
					ADDR_DEV_ADDR: dev_addr_q <= reg_req.wdata[DEV_ADDR_W-1:0];
					ADDR_CLEAR: clr_q <= reg_req.wdata;
					ADDR_TOP_CHANNEL_DIAGNOSTIC_REG: clr_link_q <= reg_req.wdata[LINK_ERR_BIT];
					default: ;
				endcase
			end
		end
	end

	// pack a channel pair into its diagnostic register layout
	function automatic logic [7:0] pair_reg(input logic oc_hi, input logic ol_hi,
			input logic oc_lo, input logic ol_lo);
		pair_reg = 8'h00;
		pair_reg[OC_HI_BIT] = oc_hi;
		pair_reg[OL_HI_BIT] = ol_hi;
		pair_reg[OC_LO_BIT] = oc_lo;
		pair_reg[OL_LO_BIT] = ol_lo;
	endfunction : pair_reg

	// read data stand the cycle after the strobe only; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= RESET_ZERO;
		end else if (reg_req.rd) begin
			case (reg_req.addr)
				ADDR_TOP_CHANNEL_DIAGNOSTIC_REG: reg_rdata <= {link_err_q, 3'h0,
					oc_flag_q | ol_flag_q};
				ADDR_CHANNEL_DIAGNOSTIC_REG_B21: reg_rdata <= pair_reg(oc_flag_q[1], ol_flag_q[1],
					oc_flag_q[0], ol_flag_q[0]);
				ADDR_CHANNEL_DIAGNOSTIC_REG_B43: reg_rdata <= pair_reg(oc_flag_q[3], ol_flag_q[3],
					oc_flag_q[2], ol_flag_q[2]);
				ADDR_STATUS: reg_rdata <= {state_q, cmd_q};
				ADDR_FAULT_MASK: reg_rdata <= fault_mask_q;
				ADDR_DEV_ADDR: reg_rdata <= {3'h0, dev_addr_q};
				default: reg_rdata <= RESET_ZERO;
			endcase
		end else begin
			reg_rdata <= RESET_ZERO;
		end
	end

	// ==========================================================
	// link watchdog
	// the heartbeat must toggle within the timeout or the link counts as lost
	logic alive_d_q;
	logic [7:0] wd_cnt_q;
	logic link_bad;
	// carrier order is heartbeat, frame error, supply good: bit 0 is the supply level
	assign link_bad = lk_q[1] | ~lk_q[0] | (wd_cnt_q >= 8'(LINK_TIMEOUT_CYC));

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			alive_d_q <= 1'b0;
			wd_cnt_q <= RESET_ZERO;
		end else begin
			alive_d_q <= lk_q[2];
			if (lk_q[2] != alive_d_q) begin
				wd_cnt_q <= RESET_ZERO; // link verified again
			end else if (wd_cnt_q < 8'(LINK_TIMEOUT_CYC)) begin
				wd_cnt_q <= wd_cnt_q + LINK_CNT_ONE;
			end
		end
	end

	// link error flag: set wins over clear, clear ignored while the cause holds
	// cleared from the top register only; the 8-bit clear register has no room for it,
	// and its bit 7 belongs to the channel three open-load clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			link_err_q <= 1'b0;
		end else if (link_bad) begin
			link_err_q <= 1'b1; // error, silence or dead switch side
		end else if (clr_link_q) begin
			link_err_q <= 1'b0;
		end
	end

	// ==========================================================
	// channel flags
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			oc_flag_q <= '0;
			ol_flag_q <= '0;
		end else begin
			// set only when commanded on; set wins over clear
			oc_flag_q <= (oc_flag_q & ~clr_q[NUM_CH-1:0]) | (oc_q & cmd_q);
			// set only when off; load above threshold reported high
			ol_flag_q <= (ol_flag_q & ~clr_q[CLR_OL_LSB +: NUM_CH]) | (ol_q & ~cmd_q);
		end
	end

	// ==========================================================
	// output gating and indicators
	// over-current flag and link error both force the channel off
	logic [NUM_CH-1:0] state_d;
	assign state_d = (link_err_q || link_bad) ? '0 : (cmd_q & ~oc_flag_q & ~oc_q);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= '0;
			switch_drive <= '0;
			channel_status_led_n_o <= '0;
			channel_status_led_n_oe <= '0;
			open_load_indicator_n_o <= 1'b0;
			open_load_indicator_n_oe <= 1'b0;
			fault_indicator_n_o <= 1'b0;
			fault_indicator_n_oe <= 1'b0;
		end else begin
			state_q <= state_d;
			switch_drive <= state_d; // open-load flag does not touch this
			// leds follow the real output state, pulled low when on
			channel_status_led_n_o <= '0;
			channel_status_led_n_oe <= state_d;
			open_load_indicator_n_o <= 1'b0;
			open_load_indicator_n_oe <= |ol_flag_q;
			fault_indicator_n_o <= 1'b0;
			fault_indicator_n_oe <= (fault_mask_q[0] & |oc_flag_q)
				| (fault_mask_q[1] & |ol_flag_q) | (fault_mask_q[2] & link_err_q);
		end
	end

	// ==========================================================
	// assertions
	a_oc_forces_off: assert property (@(posedge clk) disable iff (sys_rst)
		|oc_flag_q |=> ((switch_drive & $past(oc_flag_q)) == '0))
		else $error("output on while over-current flag set");
	a_ol_needs_off: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(ol_flag_q[0]) |-> $past(~cmd_q[0]))
		else $error("open-load flag rose while commanded on");
	a_link_kills_all: assert property (@(posedge clk) disable iff (sys_rst)
		link_err_q |=> switch_drive == '0)
		else $error("output on during link error");
	a_link_err_sticky: assert property (@(posedge clk) disable iff (sys_rst)
		link_err_q && !clr_link_q |=> link_err_q)
		else $error("link error cleared without request");
	a_led_mirror: assert property (@(posedge clk) disable iff (sys_rst)
		channel_status_led_n_oe == switch_drive)
		else $error("led differs from output state");
	a_ol_pin: assert property (@(posedge clk) disable iff (sys_rst)
		|ol_flag_q |=> open_load_indicator_n_oe)
		else $error("open-load pin not asserted");
	a_wd_timeout: assert property (@(posedge clk) disable iff (sys_rst)
		wd_cnt_q >= 8'(LINK_TIMEOUT_CYC) |=> link_err_q)
		else $error("silent link not flagged");
	a_read_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
		!reg_req.rd |=> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_oc_needs_on: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(oc_flag_q[0]) |-> $past(cmd_q[0]))
		else $error("over-current flag rose while commanded off");
	a_unpowered_flags: assert property (@(posedge clk) disable iff (sys_rst)
		!lk_q[0] |=> link_err_q && state_q == '0)
		else $error("unpowered switch side not flagged");

	// named steps of the shutdown and recovery walk, watched on channel zero
	// a tripped channel must go dark in status, drive and led together
	sequence s_oc_tripped;
		oc_flag_q[0] && cmd_q[0];
	endsequence : s_oc_tripped
	sequence s_ch0_dark;
		!switch_drive[0] && !channel_status_led_n_oe[0] && !state_q[0];
	endsequence : s_ch0_dark
	// once flag, sense and link are clear the led must light with the output, no lag
	sequence s_ch0_ready;
		cmd_q[0] && !oc_flag_q[0] && !oc_q[0] && !link_err_q && !link_bad;
	endsequence : s_ch0_ready
	sequence s_ch0_lit;
		switch_drive[0] && channel_status_led_n_oe[0] && state_q[0];
	endsequence : s_ch0_lit
	a_oc_goes_dark: assert property (@(posedge clk) disable iff (sys_rst)
		s_oc_tripped |=> s_ch0_dark)
		else $error("tripped channel still shown on");
	a_led_recovers: assert property (@(posedge clk) disable iff (sys_rst)
		s_ch0_ready |=> s_ch0_lit)
		else $error("recovered channel not shown on");
endmodule : switch_fault_diagnostics

/* test/link_partner.sv */
// switch-side link partner: heartbeat toggle, framing error and supply level
// assumes the bench clock; the bench sets the three controls
`timescale 1ns/10ps
module link_partner (
	input wire logic clk,
	input wire logic beat_en,
	input wire logic powered,
	input wire logic frame_bad,
	output channel_diagnostic_reg_pkg::link_in_s link
);
	import channel_diagnostic_reg_pkg::*;
	logic [3:0] beat_cnt_q = 4'h0;
	logic alive_q = 1'b0;
	// ================
	// heartbeat
	// an unpowered side leaves the line wandering, so it must not read as alive
	always @(posedge clk) begin
		beat_cnt_q <= beat_cnt_q + 4'h1;
		if (!powered) alive_q <= ~alive_q;
		else if (beat_en && beat_cnt_q == 4'hf) alive_q <= ~alive_q;
	end
	assign link = '{alive: alive_q, frame_err: frame_bad, sw_powered: powered};
endmodule : link_partner

/* test/tb.sv */
// self-checking bench for the switch fault diagnostics block
// assumes the link partner model and a 200 MHz clock
`timescale 1ns/10ps
module tb;
	import channel_diagnostic_reg_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] cmd = 4'h0, oc_s = 4'h0, ol_s = 4'h0;
	logic beat_en = 1'b1, powered = 1'b1, frame_bad = 1'b0;
	reg_req_s req = '0;
	link_in_s link;
	logic [7:0] rdata;
	logic [3:0] drive, led_o, led_oe;
	logic ol_o, ol_oe, flt_o, flt_oe;
	// reference model state
	logic [3:0] m_oc = 4'h0, m_ol = 4'h0;
	logic m_link = 1'b0;
	logic [7:0] m_mask = FAULT_MASK_RST;
	int error_cnt = 0, checks = 0, cyc = 0;

	switch_fault_diagnostics switch_fault_diagnostics_i (.clk(clk), .sys_rst(sys_rst),
		.parallel_channel_input(cmd), .overcurrent_sense(oc_s), .open_load_sense(ol_s),
		.link_in(link), .reg_req(req), .reg_rdata(rdata), .switch_drive(drive),
		.channel_status_led_n_o(led_o), .channel_status_led_n_oe(led_oe),
		.open_load_indicator_n_o(ol_o), .open_load_indicator_n_oe(ol_oe),
		.fault_indicator_n_o(flt_o), .fault_indicator_n_oe(flt_oe));
	link_partner link_partner_i (.clk(clk), .beat_en(beat_en), .powered(powered),
		.frame_bad(frame_bad), .link(link));

	initial forever #2.5 clk = ~clk;
	// hang guard, far above the fewer than two thousand cycles the run needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// ================
	// helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask : rd
	task automatic drive_in(input logic [3:0] c, input logic [3:0] o, input logic [3:0] l);
		@(posedge clk);
		cmd <= c;
		oc_s <= o;
		ol_s <= l;
		settle(12);
	endtask : drive_in
	// compare the diagnostic and status registers and every pin level with the model; open-drain pins pulled high
	task automatic check_all();
		logic [3:0] st;
		logic f;
		st = cmd & ~m_oc & {4{~m_link}};
		f = (m_mask[0] & |m_oc) | (m_mask[1] & |m_ol) | (m_mask[2] & m_link);
		rd(ADDR_TOP_CHANNEL_DIAGNOSTIC_REG, {m_link, 3'h0, m_oc | m_ol});
		rd(ADDR_CHANNEL_DIAGNOSTIC_REG_B21, {m_oc[1], 2'h0, m_ol[1], m_oc[0], 2'h0, m_ol[0]});
		rd(ADDR_CHANNEL_DIAGNOSTIC_REG_B43, {m_oc[3], 2'h0, m_ol[3], m_oc[2], 2'h0, m_ol[2]});
		rd(ADDR_STATUS, {st, cmd});
		check({4'h0, drive}, {4'h0, st});
		check({4'h0, ~led_oe | led_o}, {4'h0, ~st});
		check({7'h0, ~ol_oe | ol_o}, {7'h0, ~|m_ol});
		check({7'h0, ~flt_oe | flt_o}, {7'h0, ~f});
	endtask : check_all
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish

	// ================
	// main sequence
	initial begin
		void'($urandom(56678));
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		settle(12);
		rd(ADDR_FAULT_MASK, FAULT_MASK_RST);
		rd(4'h7, 8'h00);
		// chain address keeps five bits only, enough for thirty-two devices
		wr(ADDR_DEV_ADDR, 8'hff);
		rd(ADDR_DEV_ADDR, 8'h1f);
		wr(ADDR_DEV_ADDR, 8'h0a);
		rd(ADDR_DEV_ADDR, 8'h0a);
		check_all();
		$display("test reset done");
		repeat (4) begin
			drive_in(4'($urandom), 4'h0, 4'h0);
			check_all();
		end
		$display("test commands done");
		// over-current while off must not flag
		drive_in(4'h0, 4'hf, 4'h0);
		check_all();
		for (int k = 0; k < 4; k++) begin
			drive_in(4'hf, 4'h1 << k, 4'h0);
			m_oc[k] = 1'b1;
			check_all();
			drive_in(4'hf, 4'h0, 4'h0);
			check_all();
			wr(ADDR_CLEAR, 8'h01 << k);
			m_oc[k] = 1'b0;
			settle(12);
			check_all();
		end
		$display("test over-current done");
		// open load while on must not flag; flags build up one channel at a time
		drive_in(4'hf, 4'h0, 4'hf);
		check_all();
		for (int k = 0; k < 4; k++) begin
			drive_in(~(4'h1 << k), 4'h0, 4'hf);
			m_ol[k] = 1'b1;
			check_all();
		end
		wr(ADDR_FAULT_MASK, 8'h07);
		m_mask = 8'h07;
		settle(4);
		rd(ADDR_FAULT_MASK, 8'h07);
		check_all();
		drive_in(4'h0, 4'h0, 4'h0);
		wr(ADDR_CLEAR, 8'hf0);
		m_ol = 4'h0;
		settle(12);
		check_all();
		$display("test open-load done");
		// link causes: silence, unpowered switch side, framing error
		drive_in(4'hf, 4'h0, 4'h0);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk);
			beat_en <= (i != 0);
			powered <= (i != 1);
			frame_bad <= (i == 2);
			settle(260);
			m_link = 1'b1;
			check_all();
			wr(ADDR_TOP_CHANNEL_DIAGNOSTIC_REG, 8'h80);
			settle(4);
			check_all();
			@(posedge clk);
			beat_en <= 1'b1;
			powered <= 1'b1;
			frame_bad <= 1'b0;
			settle(40);
			check_all();
			wr(ADDR_TOP_CHANNEL_DIAGNOSTIC_REG, 8'h80);
			m_link = 1'b0;
			settle(12);
			check_all();
		end
		$display("test link done");
		tally_and_finish();
	end
endmodule : tb
